// >>> hw/dtap_framer.sv
// DS3 transmit framer core with alarm and maintenance pattern override,
// plus the payload FIFO that feeds it.
// Assumes host port, receive flags and line side all run on mclk_i.
`timescale 1ns/1ns

module dtap_fifo #(
  parameter int DW    = 1,
  parameter int DEPTH = 8
) (
  input  wire logic          mclk_i,      // Core clock
  input  wire logic          rst_i,       // Async reset, high
  input  wire logic          ce_i,        // Clock enable
  input  wire logic [DW-1:0] in_data_i,   // Write data
  input  wire logic          in_valid_i,  // Write offered
  output logic               in_ready_o,  // Room available
  output logic      [DW-1:0] out_data_o,  // Head data
  output logic               out_valid_o, // Head present
  input  wire logic          out_ready_i  // Head taken
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [DW-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_q;
  logic [AW-1:0] rptr_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          push;
  logic          pop;

  assign push        = ce_i & in_valid_i & in_ready_o;
  assign pop         = ce_i & out_valid_o & out_ready_i;
  assign out_valid_o = cnt_q != '0;
  assign out_data_o  = mem[rptr_q];

  // Occupancy after this beat
  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + CW'(1);
    end else if (pop && !push) begin
      cnt_d = cnt_q - CW'(1);
    end
  end

  // Storage has no reset; only written slots are ever read
  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[wptr_q] <= in_data_i;
    end
  end

  // Pointers wrap; depth is a power of two
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wptr_q <= '0;
      rptr_q <= '0;
    end else begin
      if (push) begin
        wptr_q <= wptr_q + AW'(1);
      end
      if (pop) begin
        rptr_q <= rptr_q + AW'(1);
      end
    end
  end

  // Ready is registered so the source sees a clean flop
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q      <= '0;
      in_ready_o <= 1'b1;
    end else if (ce_i) begin
      cnt_q      <= cnt_d;
      in_ready_o <= cnt_d != CW'(DEPTH);
    end
  end

endmodule

module dtap_framer #(
  parameter int FIFO_DEPTH = dtap_pkg::FIFO_DEPTH
) (
  input  wire logic       mclk_i,        // Core and line clock
  input  wire logic       rst_i,         // Async reset, high
  input  wire logic       ce_i,          // Clock enable
  input  wire logic [7:0] host_addr_i,   // Register address
  input  wire logic [7:0] host_wdata_i,  // Write data
  input  wire logic       host_wr_i,     // Write strobe
  input  wire logic       host_rd_i,     // Read strobe
  output logic      [7:0] host_rdata_o,  // Read data
  input  wire logic       pay_bit_i,     // Payload bit
  input  wire logic       pay_valid_i,   // Payload offered
  output logic            pay_ready_o,   // Payload taken
  input  wire logic       oh_bit_i,      // Overhead insert bit
  input  wire logic       oh_valid_i,    // Overhead insert valid
  input  wire logic       hdlc_bit_i,    // HDLC FEAC/DL bit
  input  wire logic       hdlc_en_i,     // HDLC active
  input  wire logic       rx_los_i,      // Near-end loss of signal
  input  wire logic       rx_oof_i,      // Near-end out of frame
  input  wire logic       rx_ais_i,      // Near-end AIS seen
  input  wire logic       line_ready_i,  // Line takes bit
  output logic            tx_bit_o,      // Line bit
  output logic            tx_valid_o,    // Line bit valid
  output logic            frame_start_o  // First bit of M-frame
);

  logic [7:0] cfg_q;
  logic [7:0] act_q;
  logic [2:0] sub_q;
  logic [2:0] blk_q;
  logic [6:0] bit_q;
  logic [1:0] pat_q;
  logic       par_acc_q;
  logic       par_q;
  logic       bit_d;

  logic adv;
  logic wrap;
  logic is_oh;
  logic is_x;
  logic is_p;
  logic is_m;
  logic is_f;
  logic is_c;
  logic is_pay;
  logic los_m;
  logic ais_m;
  logic idle_m;
  logic yel_m;
  logic xf_m;
  logic normal;
  logic auto_yel;
  logic f_bit;
  logic f_valid;
  logic f_pop;

  // A beat moves when the line has room or nothing is pending
  assign adv  = ce_i & (~tx_valid_o | line_ready_i);
  assign wrap = adv & (bit_q == dtap_pkg::LAST_BIT) & (blk_q == dtap_pkg::LAST_BLK)
              & (sub_q == dtap_pkg::LAST_SUB);

  // Slot decode within the M-frame
  assign is_oh  = bit_q == 7'h0;
  assign is_x   = is_oh & (blk_q == 3'h0) & (sub_q <= 3'h1);
  assign is_p   = is_oh & (blk_q == 3'h0) & (sub_q == 3'h2 || sub_q == 3'h3);
  assign is_m   = is_oh & (blk_q == 3'h0) & (sub_q >= 3'h4);
  assign is_f   = is_oh & blk_q[0];
  assign is_c   = is_oh & (blk_q != 3'h0) & ~blk_q[0];
  assign is_pay = ~is_oh;

  // Priority chain over the frame-latched controls
  assign los_m  = act_q[dtap_pkg::CFG_LOS];
  assign ais_m  = ~los_m & act_q[dtap_pkg::CFG_AIS];
  assign idle_m = ~los_m & ~ais_m & act_q[dtap_pkg::CFG_IDLE];
  assign yel_m  = ~los_m & ~ais_m & ~idle_m & act_q[dtap_pkg::CFG_YEL];
  assign xf_m   = ~los_m & ~ais_m & ~idle_m & ~yel_m & act_q[dtap_pkg::CFG_XFORCE];
  assign normal = ~los_m & ~ais_m & ~idle_m;

  // Remote alarm raised from receive red alarm conditions
  assign auto_yel = (act_q[dtap_pkg::CFG_AR_LOS] & rx_los_i)
                  | (act_q[dtap_pkg::CFG_AR_OOF] & rx_oof_i)
                  | (act_q[dtap_pkg::CFG_AR_AIS] & rx_ais_i);

  // Payload is held back, not discarded, while a pattern overrides it
  assign f_pop = adv & is_pay & normal & f_valid;

  dtap_fifo #(
    .DW    (1),
    .DEPTH (FIFO_DEPTH)
  ) u_dtap_fifo (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .in_data_i   (pay_bit_i),
    .in_valid_i  (pay_valid_i),
    .in_ready_o  (pay_ready_o),
    .out_data_o  (f_bit),
    .out_valid_o (f_valid),
    .out_ready_i (f_pop)
  );

  // Host writes land in the shadow copy at once
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_q <= dtap_pkg::CFG_RESET;
    end else if (ce_i && host_wr_i && host_addr_i == dtap_pkg::CFG_ADDR) begin
      cfg_q <= host_wdata_i;
    end
  end

  // Active copy follows only at frame wrap, so no frame is mixed
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      act_q <= dtap_pkg::CFG_RESET;
    end else if (wrap) begin
      act_q <= cfg_q;
    end
  end

  // Registered read port; unmapped addresses read zero
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      host_rdata_o <= 8'h00;
    end else if (ce_i && host_rd_i) begin
      unique case (host_addr_i)
        dtap_pkg::CFG_ADDR: begin
          host_rdata_o <= cfg_q;
        end
        dtap_pkg::STAT_ADDR: begin
          host_rdata_o <= {2'h0, xf_m, yel_m, los_m, ais_m, idle_m, auto_yel};
        end
        default: begin
          host_rdata_o <= 8'h00;
        end
      endcase
    end
  end

  // Bit, block and subframe position counters
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      bit_q <= 7'h0;
      blk_q <= 3'h0;
      sub_q <= 3'h0;
    end else if (adv) begin
      if (bit_q == dtap_pkg::LAST_BIT) begin
        bit_q <= 7'h0;
        if (blk_q == dtap_pkg::LAST_BLK) begin
          blk_q <= 3'h0;
          sub_q <= (sub_q == dtap_pkg::LAST_SUB) ? 3'h0 : sub_q + 3'h1;
        end else begin
          blk_q <= blk_q + 3'h1;
        end
      end else begin
        bit_q <= bit_q + 7'h1;
      end
    end
  end

  // Fill pattern phase restarts each frame so every frame opens alike
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pat_q <= 2'h0;
    end else if (wrap) begin
      pat_q <= 2'h0;
    end else if (adv && is_pay) begin
      pat_q <= pat_q + 2'h1;
    end
  end

  // Next line bit from slot, mode and sources
  always_comb begin
    bit_d = 1'b1;
    if (los_m) begin
      bit_d = 1'b0;
    end else if (is_x) begin
      if (ais_m || idle_m) begin
        bit_d = 1'b1;
      end else if (yel_m) begin
        bit_d = 1'b0;
      end else if (xf_m) begin
        bit_d = 1'b1;
      end else if (oh_valid_i) begin
        bit_d = oh_bit_i;
      end else begin
        bit_d = ~auto_yel;
      end
    end else if (is_f) begin
      bit_d = dtap_pkg::F_PATTERN[blk_q[2:1]];
    end else if (is_m) begin
      bit_d = dtap_pkg::M_PATTERN[sub_q[1:0]];
    end else if (is_p) begin
      bit_d = par_q;
    end else if (is_c) begin
      if (ais_m) begin
        bit_d = 1'b0;
      end else if (idle_m && sub_q == dtap_pkg::SUB_CP) begin
        bit_d = 1'b0;
      end else if (oh_valid_i) begin
        bit_d = oh_bit_i;
      end else if (hdlc_en_i && (sub_q == dtap_pkg::SUB_DL
                   || (sub_q == dtap_pkg::SUB_FEAC && blk_q == dtap_pkg::BLK_FEAC))) begin
        bit_d = hdlc_bit_i;
      end else if (sub_q == dtap_pkg::SUB_CP) begin
        bit_d = par_q;
      end else begin
        bit_d = 1'b1;
      end
    end else if (ais_m) begin
      bit_d = ~pat_q[0];
    end else if (idle_m) begin
      bit_d = ~pat_q[1];
    end else if (f_valid) begin
      bit_d = f_bit;
    end else begin
      bit_d = 1'b1;
    end
  end

  // Parity over sent payload feeds the next frame's P and CP bits
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      par_acc_q <= 1'b0;
      par_q     <= 1'b0;
    end else if (wrap) begin
      par_acc_q <= 1'b0;
      par_q     <= par_acc_q ^ bit_d;
    end else if (adv && is_pay) begin
      par_acc_q <= par_acc_q ^ bit_d;
    end
  end

  // Line output register; holds while the line stalls
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_bit_o      <= 1'b0;
      tx_valid_o    <= 1'b0;
      frame_start_o <= 1'b0;
    end else if (adv) begin
      tx_bit_o      <= bit_d;
      tx_valid_o    <= 1'b1;
      frame_start_o <= (sub_q == 3'h0) && (blk_q == 3'h0) && is_oh;
    end
  end

  // Checks on the line output against mode and slot, plus mode priority and frame latching of controls
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  a_los_zero: assert property (adv && los_m |=> !tx_bit_o)
    else $error("signal-loss bit not zero");

  a_yel_xbit: assert property (adv && yel_m && is_x |=> !tx_bit_o)
    else $error("yellow X-bit not zero");

  a_xforce_xbit: assert property (adv && xf_m && is_x |=> tx_bit_o)
    else $error("forced X-bit not one");

  a_idle_cp: assert property (adv && idle_m && is_c && sub_q == dtap_pkg::SUB_CP |=> !tx_bit_o)
    else $error("idle CP-bit not zero");

  a_ais_cbit: assert property (adv && ais_m && is_c |=> !tx_bit_o)
    else $error("AIS C-bit not zero");

  a_auto_yel: assert property (adv && normal && !yel_m && !xf_m && is_x && !oh_valid_i && auto_yel
                               |=> !tx_bit_o)
    else $error("automatic yellow not sent");

  a_mode_prio: assert property ($onehot0({los_m, ais_m, idle_m, yel_m, xf_m}))
    else $error("more than one override mode active");

  a_frame_latch: assert property (!$stable(act_q) |-> $past(wrap))
    else $error("controls changed inside a frame");

  // F1 and F4 carry one, F2 and F3 zero; spelled out apart from the pattern constant
  a_fbit_valid: assert property (adv && !los_m && is_f
                                 |=> tx_bit_o == $past(blk_q == 3'h1 || blk_q == 3'h7))
    else $error("F-bit wrong");

  a_pbit_valid: assert property (adv && !los_m && is_p |=> tx_bit_o == $past(par_q))
    else $error("P-bit differs from parity");

  a_pay_pass: assert property (adv && is_pay && normal && f_valid |=> tx_bit_o == $past(f_bit))
    else $error("payload bit not passed through");

  c_los_frame: cover property (wrap && los_m);
  c_idle_pay: cover property (adv && idle_m && is_pay);
  c_auto_yel: cover property (adv && auto_yel && is_x);
  c_backpress: cover property (!pay_ready_o ##1 pay_ready_o);

endmodule

// >>> hw/dtap_pkg.sv
// Shared constants for the DS3 transmit alarm and pattern inserter.
// Assumes one 100 MHz clock domain; one line bit per accepted beat.
package dtap_pkg;

  // Host register map
  localparam logic [7:0] CFG_ADDR  = 8'h30;
  localparam logic [7:0] STAT_ADDR = 8'h3f;
  localparam logic [7:0] CFG_RESET = 8'h2b;

  // Configuration field positions
  localparam int CFG_YEL    = 7;
  localparam int CFG_XFORCE = 6;
  localparam int CFG_IDLE   = 5;
  localparam int CFG_AIS    = 4;
  localparam int CFG_LOS    = 3;
  localparam int CFG_AR_LOS = 2;
  localparam int CFG_AR_OOF = 1;
  localparam int CFG_AR_AIS = 0;

  // Status field positions
  localparam int ST_AUTO   = 0;
  localparam int ST_IDLE   = 1;
  localparam int ST_AIS    = 2;
  localparam int ST_LOS    = 3;
  localparam int ST_YEL    = 4;
  localparam int ST_XFORCE = 5;

  // M-frame geometry: 7 subframes, 8 blocks, 1 overhead + 84 payload bits
  localparam logic [2:0] LAST_SUB = 3'h6;
  localparam logic [2:0] LAST_BLK = 3'h7;
  localparam logic [6:0] LAST_BIT = 7'h54;

  // Overhead slot locations
  localparam logic [2:0] SUB_CP   = 3'h2;
  localparam logic [2:0] SUB_DL   = 3'h4;
  localparam logic [2:0] SUB_FEAC = 3'h0;
  localparam logic [2:0] BLK_FEAC = 3'h6;

  // Framing patterns, indexed F1..F4 and M1..M3
  localparam logic [3:0] F_PATTERN = 4'h9;
  localparam logic [2:0] M_PATTERN = 3'h2;

  // Payload buffer depth
  localparam int FIFO_DEPTH = 8;

endpackage

// >>> testbench/dtap_line_model.sv
// Line-side receiver model standing where the line interface path would be.
// Assumes the framer clock drives it and frames are delimited by frame_start_i.
`timescale 1ns/1ns

module dtap_line_model (
  input  wire logic mclk_i,        // Line clock
  input  wire logic rst_i,         // Async reset, high
  input  wire logic slow_i,        // Stall one cycle in eight
  input  wire logic tx_bit_i,      // Line bit
  input  wire logic tx_valid_i,    // Line bit valid
  input  wire logic frame_start_i, // First bit of M-frame
  output logic      line_ready_o   // Bit accepted this cycle
);
  logic       cur [0:4759]; // Frame being received
  logic       cap [0:4759]; // Last whole frame
  int         pos;
  int         cap_len;
  int         frame_cnt;
  logic [2:0] tick = 3'h0; // Stall phase; ready settles during reset

  // Back-pressure moves off the sampling edge so the framer sees a settled level
  always @(negedge mclk_i) begin
    tick <= tick + 3'h1;
    line_ready_o <= !(slow_i && tick == 3'h0);
  end

  // Collect accepted bits; a frame closes when the next one starts
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pos = 0;
      cap_len = 0;
      frame_cnt = 0;
    end else if (tx_valid_i && line_ready_o) begin
      if (frame_start_i && pos > 0) begin
        cap = cur;
        cap_len = pos;
        frame_cnt++;
        pos = 0;
      end
      if (pos < 4760) cur[pos] = tx_bit_i; // Overlong frames show in cap_len
      pos++;
    end
  end
endmodule

// >>> testbench/tb_ds3_tx_alarm_pattern_insert.sv
// Self-checking bench for the DS3 transmit alarm and pattern inserter.
// Assumes dtap_framer on one 100 MHz clock with the line model as its far side.
`timescale 1ns/1ns

module tb_ds3_tx_alarm_pattern_insert;
  typedef struct packed {
    logic [7:0] cfg;
    logic [2:0] rx;
    logic       ohv;
    logic       ohb;
    logic       hen;
    logic       hb;
    logic       pv;
  } dtap_case_t;

  logic       mclk_i, rst_i, ce_i, host_wr_i, host_rd_i, pay_bit_i, pay_valid_i, pay_ready_o;
  logic       oh_bit_i, oh_valid_i, hdlc_bit_i, hdlc_en_i, rx_los_i, rx_oof_i, rx_ais_i;
  logic       line_ready_i, tx_bit_o, tx_valid_o, frame_start_o, slow, par;
  logic [7:0] host_addr_i, host_wdata_i, host_rdata_o, d;
  dtap_case_t cur;
  int         err_count = 0;
  int         n_checks = 0;

  dtap_framer u_dtap_framer (
    .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .host_addr_i(host_addr_i),
    .host_wdata_i(host_wdata_i), .host_wr_i(host_wr_i), .host_rd_i(host_rd_i),
    .host_rdata_o(host_rdata_o), .pay_bit_i(pay_bit_i), .pay_valid_i(pay_valid_i),
    .pay_ready_o(pay_ready_o), .oh_bit_i(oh_bit_i), .oh_valid_i(oh_valid_i),
    .hdlc_bit_i(hdlc_bit_i), .hdlc_en_i(hdlc_en_i), .rx_los_i(rx_los_i), .rx_oof_i(rx_oof_i),
    .rx_ais_i(rx_ais_i), .line_ready_i(line_ready_i), .tx_bit_o(tx_bit_o),
    .tx_valid_o(tx_valid_o), .frame_start_o(frame_start_o)
  );

  dtap_line_model u_dtap_line_model (
    .mclk_i(mclk_i), .rst_i(rst_i), .slow_i(slow), .tx_bit_i(tx_bit_o),
    .tx_valid_i(tx_valid_o), .frame_start_i(frame_start_o), .line_ready_o(line_ready_i)
  );

  // Free-running 100 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  task automatic results();
    $display("Checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Host strobes are held one full cycle so exactly one edge takes them
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge mclk_i);
    host_addr_i = a;
    host_wdata_i = v;
    host_wr_i = 1'b1;
    @(negedge mclk_i);
    host_wr_i = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge mclk_i);
    host_addr_i = a;
    host_rd_i = 1'b1;
    @(negedge mclk_i);
    host_rd_i = 1'b0;
    @(negedge mclk_i);
    v = host_rdata_o;
  endtask

  // Effective modes after priority: {xforce, yellow, los, ais, idle}
  function automatic logic [4:0] eff(input logic [7:0] c);
    logic los, ais, idl, yel;
    los = c[dtap_pkg::CFG_LOS];
    ais = !los && c[dtap_pkg::CFG_AIS];
    idl = !los && !ais && c[dtap_pkg::CFG_IDLE];
    yel = !(los || ais || idl) && c[dtap_pkg::CFG_YEL];
    return {!(los || ais || idl || yel) && c[dtap_pkg::CFG_XFORCE], yel, los, ais, idl};
  endfunction

  // Expected line bit at frame position p; x marks bits still in the buffer
  function automatic logic exp_bit(input dtap_case_t c, input int p, input logic pr);
    int         s, b, q;
    logic [4:0] m;
    m = eff(c.cfg);
    s = p / 680;
    b = (p % 680) / 85;
    q = p - (s * 8 + b + 1);
    if (m[2]) return 1'b0;
    if (p % 85 != 0) begin
      if (m[1]) return !q[0];
      if (m[0]) return (q % 4) < 2;
      if (!c.pv && q < 8) return 1'bx;
      return !c.pv;
    end
    if (b == 0 && s < 2) begin
      if (m[4] || m[1] || m[0]) return 1'b1;
      if (m[3]) return 1'b0;
      return c.ohv ? c.ohb : !(|(c.cfg[2:0] & c.rx));
    end
    if (b == 0) return (s < 4) ? pr : (s == 5);
    if (b % 2 == 1) return (b == 1 || b == 7);
    if (m[1] || (m[0] && s == 2)) return 1'b0;
    if (c.ohv) return c.ohb;
    if (c.hen && ((s == 0 && b == 6) || s == 4)) return c.hb;
    return (s == 2) ? pr : 1'b1;
  endfunction

  task automatic check_frame(input dtap_case_t c);
    int   bad;
    logic e, np;
    bad = -1;
    np = 1'b0;
    for (int p = 0; p < 4760; p++) begin
      e = exp_bit(c, p, par);
      if (e !== 1'bx && u_dtap_line_model.cap[p] !== e && bad < 0) bad = p;
      if (p % 85 != 0) np ^= u_dtap_line_model.cap[p];
    end
    n_checks += 2;
    if (u_dtap_line_model.cap_len != 4760) begin
      err_count++;
      $display("Error frame length expected 4760 seen %0d", u_dtap_line_model.cap_len);
    end
    if (bad >= 0) begin
      err_count++;
      $display("Error frame bit %0d expected %b seen %b", bad, exp_bit(c, bad, par),
               u_dtap_line_model.cap[bad]);
    end
    par = np;
  endtask

  // Apply a case late in a frame so it lands at the next wrap, then judge the old frame
  task automatic run(input dtap_case_t c);
    int         n;
    int         fc;
    logic [4:0] m;
    n = 0;
    while (u_dtap_line_model.pos < 4700 && n < 7000) begin
      @(negedge mclk_i);
      n++;
    end
    m = eff(cur.cfg);
    if ((m[2] || m[1] || m[0]) && cur.pv) chk("payload ready", 8'h00, {7'h00, pay_ready_o});
    wr(dtap_pkg::CFG_ADDR, c.cfg);
    {rx_los_i, rx_oof_i, rx_ais_i} = c.rx;
    oh_valid_i = c.ohv;
    oh_bit_i = c.ohb;
    hdlc_en_i = c.hen;
    hdlc_bit_i = c.hb;
    fc = u_dtap_line_model.frame_cnt;
    while (u_dtap_line_model.frame_cnt == fc && n < 14000) begin
      @(negedge mclk_i);
      n++;
    end
    if (u_dtap_line_model.frame_cnt == fc) begin
      err_count++;
      $display("Error frame count expected %0d seen %0d", fc + 1, u_dtap_line_model.frame_cnt);
    end
    pay_valid_i = c.pv;
    check_frame(cur);
    cur = c;
    m = eff(c.cfg);
    rd(dtap_pkg::STAT_ADDR, d);
    chk("status", {2'b00, m, |(c.cfg[2:0] & c.rx)}, d);
    rd(dtap_pkg::CFG_ADDR, d);
    chk("config", c.cfg, d);
  endtask

  // Hang guard well beyond thirteen stalled frames
  initial begin
    repeat (100000) @(posedge mclk_i);
    err_count++;
    $display("Error watchdog expected finish seen timeout");
    results();
  end

  initial begin
    ce_i = 1'b1;
    rst_i = 1'b1;
    host_addr_i = 8'h00;
    host_wdata_i = 8'h00;
    host_wr_i = 1'b0;
    host_rd_i = 1'b0;
    pay_bit_i = 1'b0;
    pay_valid_i = 1'b1;
    oh_bit_i = 1'b0;
    oh_valid_i = 1'b0;
    hdlc_bit_i = 1'b0;
    hdlc_en_i = 1'b0;
    {rx_los_i, rx_oof_i, rx_ais_i} = 3'h0;
    slow = 1'b0;
    par = 1'b0;
    cur = {8'h2b, 3'h0, 5'b00001};
    repeat (3) @(negedge mclk_i);
    rst_i = 1'b0;
    rd(dtap_pkg::CFG_ADDR, d);
    chk("config reset", dtap_pkg::CFG_RESET, d);
    wr(dtap_pkg::STAT_ADDR, 8'hff);
    wr(8'h31, 8'hff);
    rd(8'h31, d);
    chk("unmapped", 8'h00, d);
    rd(dtap_pkg::STAT_ADDR, d);
    chk("status reset", 8'h08, d);
    run({8'hff, 3'h7, 5'b00001});
    run({8'hf0, 3'h0, 5'b00001});
    run({8'he0, 3'h0, 5'b00001});
    run({8'hc0, 3'h0, 5'b00001});
    run({8'h40, 3'h0, 5'b00001});
    run({8'h00, 3'h7, 5'b00101});
    slow = 1'b1;
    run({8'h00, 3'h0, 5'b10001});
    for (int k = 0; k < 3; k++) begin
      run({8'h01 << k, 3'h1 << k, 5'b00001});
    end
    run({8'h03, 3'h4, 5'b00000});
    run({8'h2b, 3'h0, 5'b00001});
    // One more frame so the final signal-loss frame is judged as well
    run({8'h00, 3'h0, 5'b00001});
    results();
  end
endmodule
